//--- src/swbc_top.sv
// byte write/read commands from a two-wire host onto a single-wire bus
// What this block does
// - command A5h plus one data byte sends that byte as eight slots
// - write-byte while busy: no acknowledge of code or data, command dropped
// - write-byte ends within eight slot periods plus 262.5ns of last bit
// - write slots start within 262.5ns of last data bit, before its acknowledge
// - byte arrives MSB first, goes out LSB first, so held whole first
// - accepting a byte command points the read pointer at status
// - write uses speed, strong and active pullup; read only speed and active
// - slots use the current timing durations and weak pullup selection
// - command 96h runs eight read slots and stores the byte
// - each read slot is a write-one slot whose level is sampled
// - read-byte while busy: code not acknowledged, command ignored
// - read slots start within 262.5ns of code acknowledge, end eight slots later
// - each read slot samples the line at the master sample time
`timescale 1ns/1ps
module swbc_top
    import swbc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic owIn,
    output logic owOut,
    output logic owOe,
    output logic activePullupOut,
    output logic strongPullupOut,
    output logic weakPullupSelOut,
    output logic busBusyFlag
);
    localparam int ACT_WIN = ACT_MAX_CYC - SYNC_LAT;

    swbc_state_t st_r;
    swbc_state_t st_nxt;
    logic sclS;
    logic sdaS;
    logic owS;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic startW;
    logic startR;
    logic okNow;
    logic [31:0] tim;
    logic [15:0] w0l;
    logic [15:0] recDur;
    logic [15:0] w1l;
    logic [15:0] msr;
    logic [15:0] lowCyc;
    logic [16:0] slotEnd;
    logic curBit;
    logic fifoInReady;
    logic fifoOutValid;
    logic [7:0] fifoData;
    logic popNow;
    logic access;
    logic [31:0] rdMux;
    logic rdErr;

    swbc_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
        .clk(ref_clk),
        .rst(rst),
        .d({sclIn, sdaIn, owIn}),
        .q({sclS, sdaS, owS})
    );

    // read byte waits here until software drains it
    swbc_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst(rst),
        .inValid(st_r.pushV),
        .inData(st_r.rxByte),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoData),
        .outReady(popNow)
    );

    assign sclRise = sclS & ~st_r.sclPrev;
    assign sclFall = ~sclS & st_r.sclPrev;
    assign startCond = sclS & st_r.sclPrev & st_r.sdaPrev & ~sdaS;
    assign stopCond = sclS & st_r.sclPrev & ~st_r.sdaPrev & sdaS;

    // timing is read live, so a change mid-command reshapes the slot in progress
    assign tim = st_r.cfg.overdriveSpeedSelect ? st_r.tOvd : st_r.tStd;
    assign w0l = tim[TIM_W0L_LSB +: 16];
    assign recDur = tim[TIM_REC_LSB +: 16];
    assign w1l = {8'h00, st_r.cfg.overdriveSpeedSelect ? st_r.tSamp[SAMP_W1L_OVD_LSB +: 8]
                                                      : st_r.tSamp[SAMP_W1L_STD_LSB +: 8]};
    assign msr = {8'h00, st_r.cfg.overdriveSpeedSelect ? st_r.tSamp[SAMP_MSR_OVD_LSB +: 8]
                                                      : st_r.tSamp[SAMP_MSR_STD_LSB +: 8]};
    assign slotEnd = {1'b0, w0l} + {1'b0, recDur} - 17'h00001;
    assign curBit = st_r.isRead | st_r.txByte[st_r.slotIdx];
    assign lowCyc = curBit ? w1l : w0l;

    assign access = psel & penable;
    assign popNow = access & st_r.pready & ~pwrite & (paddr == ADDR_RDATA);

    always_comb begin
        rdErr = 1'b0;
        case (paddr)
            ADDR_CFG: rdMux = {28'h0000000, st_r.cfg};
            ADDR_TSTD: rdMux = st_r.tStd;
            ADDR_TOVD: rdMux = st_r.tOvd;
            ADDR_TSAMP: rdMux = st_r.tSamp;
            ADDR_STATUS: rdMux = {27'h0000000, fifoOutValid, ~fifoInReady, st_r.rdPtr,
                                  st_r.spuOn, st_r.busBusyFlag};
            ADDR_RDATA: rdMux = {23'h000000, fifoOutValid, fifoData};
            ADDR_PTR: rdMux = {31'h00000000, st_r.rdPtr};
            default: begin
                rdMux = 32'h00000000;
                rdErr = 1'b1;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        startW = 1'b0;
        startR = 1'b0;
        okNow = 1'b0;

        // register bus: answer one cycle into the access phase
        if (access && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = pwrite ? 32'h00000000 : rdMux;
            st_nxt.pslverr = rdErr;
        end else begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
        if (access && st_r.pready && pwrite) begin
            case (paddr)
                ADDR_CFG: st_nxt.cfg = swbc_cfg_t'(pwdata[3:0]);
                ADDR_TSTD: st_nxt.tStd = pwdata;
                ADDR_TOVD: st_nxt.tOvd = pwdata;
                ADDR_TSAMP: st_nxt.tSamp = pwdata;
                ADDR_PTR: st_nxt.rdPtr = pwdata[0];
                default: st_nxt.rdPtr = st_r.rdPtr;
            endcase
        end

        // two-wire host side
        st_nxt.sclPrev = sclS;
        st_nxt.sdaPrev = sdaS;
        if (stopCond) begin
            st_nxt.hst = H_IDLE;
            st_nxt.sdaOe = 1'b1;
            st_nxt.cmdOk = 1'b0;
        end else if (startCond) begin
            st_nxt.hst = H_BITS;
            st_nxt.bitCnt = 4'h0;
            st_nxt.byteIdx = 1'b0;
            st_nxt.cmdOk = 1'b0;
            st_nxt.sdaOe = 1'b1;
        end else begin
            unique case (st_r.hst)
                H_IDLE: st_nxt.hst = H_IDLE;
                H_BITS: begin
                    if (sclRise) begin
                        st_nxt.shift = {st_r.shift[6:0], sdaS};
                        st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                    end
                    if (sclFall && st_r.bitCnt == BIT_COUNT_FULL) begin
                        st_nxt.hst = H_ACK;
                        st_nxt.bitCnt = 4'h0;
                        if (!st_r.byteIdx) begin
                            // busy refuses any code; a full read queue refuses only the read code
                            okNow = !st_r.busBusyFlag && (st_r.shift == CMD_WRITE_BYTE ||
                                (st_r.shift == CMD_READ_BYTE && fifoInReady));
                            st_nxt.cmd = st_r.shift;
                            st_nxt.cmdOk = okNow;
                            st_nxt.sdaOe = !okNow;
                            if (okNow) begin
                                st_nxt.rdPtr = 1'b0;
                                st_nxt.spuOn = 1'b0;
                            end
                        end else begin
                            // whole byte held; slots start before its acknowledge
                            startW = st_r.cmdOk && st_r.cmd == CMD_WRITE_BYTE;
                            st_nxt.sdaOe = !startW;
                            st_nxt.cmdOk = 1'b0;
                        end
                    end
                end
                H_ACK: begin
                    if (sclFall) begin
                        st_nxt.hst = H_BITS;
                        st_nxt.sdaOe = 1'b1;
                        st_nxt.byteIdx = 1'b1;
                        startR = !st_r.byteIdx && st_r.cmdOk && st_r.cmd == CMD_READ_BYTE;
                        if (startR) begin
                            st_nxt.cmdOk = 1'b0;
                        end
                    end
                end
            endcase
        end

        // single-wire slot engine
        if (st_r.pushV && fifoInReady) begin
            st_nxt.pushV = 1'b0;
        end
        if (startW || startR) begin
            st_nxt.sst = S_SLOT;
            st_nxt.busBusyFlag = 1'b1;
            st_nxt.isRead = startR;
            st_nxt.txByte = st_r.shift;
            st_nxt.rxByte = 8'h00;
            st_nxt.slotIdx = 3'h0;
            st_nxt.tCnt = 16'h0000;
        end else if (st_r.sst == S_SLOT) begin
            if (st_r.isRead && st_r.tCnt == msr) begin
                st_nxt.rxByte = {owS, st_r.rxByte[7:1]};
            end
            if ({1'b0, st_r.tCnt} == slotEnd) begin
                st_nxt.tCnt = 16'h0000;
                if (st_r.slotIdx == LAST_SLOT) begin
                    st_nxt.sst = S_IDLE;
                    st_nxt.busBusyFlag = 1'b0;
                    if (st_r.isRead) begin
                        st_nxt.pushV = 1'b1;
                    end else begin
                        st_nxt.spuOn = st_r.cfg.strongPullupEnable;
                    end
                end else begin
                    st_nxt.slotIdx = st_r.slotIdx + 3'h1;
                end
            end else begin
                st_nxt.tCnt = st_r.tCnt + 16'h0001;
            end
        end
        // one cycle behind the counter, same lag for every edge of the slot
        st_nxt.owOe = !(st_r.sst == S_SLOT && st_r.tCnt < lowCyc);
        st_nxt.owApu = st_r.cfg.activePullupEnable && st_r.sst == S_SLOT &&
                       st_r.tCnt >= lowCyc;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign sdaOut = st_r.sdaOut;
    assign sdaOe = st_r.sdaOe;
    assign owOut = st_r.sdaOut;
    assign owOe = st_r.owOe;
    assign activePullupOut = st_r.owApu;
    assign strongPullupOut = st_r.spuOn;
    assign weakPullupSelOut = st_r.cfg.weakPullupSelection;
    assign busBusyFlag = st_r.busBusyFlag;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_busy_refuse: assert property (
        (st_r.hst == H_BITS && sclFall && st_r.bitCnt == BIT_COUNT_FULL && !st_r.byteIdx
         && st_r.busBusyFlag) |=> st_r.sdaOe && !st_r.cmdOk ##1 !st_r.busBusyFlag || st_r.sdaOe)
        else $error("busy command was acknowledged");

    a_write_start: assert property (
        (st_r.hst == H_BITS && sclFall && st_r.bitCnt == BIT_COUNT_FULL && st_r.byteIdx &&
         st_r.cmdOk && st_r.cmd == CMD_WRITE_BYTE && lowCyc != 16'h0000)
        |-> ##[1:ACT_WIN] !st_r.owOe)
        else $error("write slots started late");

    a_read_start: assert property (
        (startR && w1l != 16'h0000) |-> ##[1:ACT_WIN] !st_r.owOe)
        else $error("read slots started late");

    a_busy_end: assert property (
        $fell(st_r.busBusyFlag) |-> $past(st_r.slotIdx) == LAST_SLOT &&
        {1'b0, $past(st_r.tCnt)} == $past(slotEnd))
        else $error("busy cleared before the eighth slot ended");

    a_hold_byte: assert property (
        startW |=> st_r.txByte == $past(st_r.shift) && st_r.slotIdx == 3'h0 &&
        st_r.busBusyFlag && !st_r.isRead)
        else $error("write byte not captured whole");

    a_read_sample: assert property (
        (st_r.sst == S_SLOT && st_r.isRead && st_r.tCnt == msr && !startW)
        |=> st_r.rxByte[7] == $past(owS))
        else $error("read slot sample misplaced");

    a_read_store: assert property (
        ($fell(st_r.busBusyFlag) && st_r.isRead) |-> st_r.pushV && !st_r.spuOn)
        else $error("read byte not stored");

    a_ptr_status: assert property (
        (st_r.hst == H_BITS && sclFall && st_r.bitCnt == BIT_COUNT_FULL && !st_r.byteIdx &&
         okNow) |=> !st_r.rdPtr && !st_r.sdaOe)
        else $error("read pointer not moved to status");

    a_pullup_sel: assert property (
        ($fell(st_r.busBusyFlag) && !st_r.isRead) |-> st_r.spuOn == $past(st_r.cfg.strongPullupEnable))
        else $error("strong pullup setting ignored");

endmodule // swbc_top

//--- src/swbc_pkg.sv
// package: constants, register map and state types of the single-wire byte-command block
package swbc_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam real ACT_MAX_NS = 262.5;
    localparam int ACT_MAX_CYC = $rtoi(ACT_MAX_NS) / CLK_PERIOD_NS;
    localparam int SYNC_LAT = 3;

    localparam logic [7:0] CMD_WRITE_BYTE = 8'hA5;
    localparam logic [7:0] CMD_READ_BYTE = 8'h96;
    localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
    localparam logic [2:0] LAST_SLOT = 3'h7;

    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 16;

    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_TSTD = 8'h04;
    localparam logic [7:0] ADDR_TOVD = 8'h08;
    localparam logic [7:0] ADDR_TSAMP = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RDATA = 8'h14;
    localparam logic [7:0] ADDR_PTR = 8'h18;

    localparam int TIM_W0L_LSB = 0;
    localparam int TIM_REC_LSB = 16;
    localparam int SAMP_W1L_STD_LSB = 0;
    localparam int SAMP_MSR_STD_LSB = 8;
    localparam int SAMP_W1L_OVD_LSB = 16;
    localparam int SAMP_MSR_OVD_LSB = 24;

    localparam logic [31:0] TSTD_RST = 32'h0064_0258;
    localparam logic [31:0] TOVD_RST = 32'h0014_0050;
    localparam logic [31:0] TSAMP_RST = 32'h1008_7840;

    // bit 0 is the speed select
    typedef struct packed {
        logic weakPullupSelection;
        logic activePullupEnable;
        logic strongPullupEnable;
        logic overdriveSpeedSelect;
    } swbc_cfg_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_BITS = 3'b010,
        H_ACK = 3'b100
    } swbc_hst_e_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_SLOT = 2'b10
    } swbc_sst_e_t;

    typedef struct packed {
        swbc_hst_e_t hst;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] cmd;
        logic byteIdx;
        logic cmdOk;
        logic sclPrev;
        logic sdaPrev;
        logic sdaOe;
        logic sdaOut;
        swbc_sst_e_t sst;
        logic busBusyFlag;
        logic isRead;
        logic [2:0] slotIdx;
        logic [15:0] tCnt;
        logic [7:0] txByte;
        logic [7:0] rxByte;
        logic pushV;
        logic owOe;
        logic owApu;
        logic spuOn;
        swbc_cfg_t cfg;
        logic [31:0] tStd;
        logic [31:0] tOvd;
        logic [31:0] tSamp;
        logic rdPtr;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } swbc_state_t;

    localparam swbc_state_t ST_RST = '{hst: H_IDLE, sst: S_IDLE, sdaOe: 1'b1, owOe: 1'b1,
        sclPrev: 1'b1, sdaPrev: 1'b1, tStd: TSTD_RST, tOvd: TOVD_RST, tSamp: TSAMP_RST,
        default: '0};

endpackage

//--- src/swbc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module swbc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } swbc_syn_t;

    swbc_syn_t st_r;
    swbc_syn_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule // swbc_sync

//--- src/swbc_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module swbc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } swbc_fst_t;

    swbc_fst_t st_r;
    swbc_fst_t st_nxt;
    logic push;
    logic pop;

    assign inReady = st_r.cnt != CNT_FULL;
    assign outValid = st_r.cnt != '0;
    assign outData = st_r.mem[st_r.rp];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = inData;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // swbc_fifo

//--- tb/swbc_host_model.sv
// host-side model of the two-wire command link
`timescale 1ns/1ps
module swbc_host_model (
    input wire logic ref_clk,
    input wire logic sdaOe,
    input wire logic sdaOut,
    output logic sclIn,
    output logic sdaLine
);
    logic hostSda = 1'b1;

    // open drain with pull-up: released means high, clock idles high between frames
    assign sdaLine = hostSda & (sdaOe | sdaOut);
    initial sclIn = 1'b1;

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one byte most significant bit first, then the acknowledge clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sclIn <= 1'b0;
            wait_cyc(2);
            hostSda <= b[i];
            wait_cyc(2);
            sclIn <= 1'b1;
            wait_cyc(4);
        end
        sclIn <= 1'b0;
        wait_cyc(2);
        hostSda <= 1'b1;
        wait_cyc(2);
        sclIn <= 1'b1;
        wait_cyc(3);
        ack = ~sdaLine;
        wait_cyc(1);
    endtask

    task automatic send_cmd(input logic [7:0] code, input logic hasData,
                            input logic [7:0] data, output logic ackCode,
                            output logic ackData);
        ackData = 1'b0;
        hostSda <= 1'b0;
        wait_cyc(4);
        send_byte(code, ackCode);
        if (hasData) begin
            send_byte(data, ackData);
        end
        sclIn <= 1'b0;
        hostSda <= 1'b0;
        wait_cyc(4);
        sclIn <= 1'b1;
        wait_cyc(4);
        hostSda <= 1'b1;
        wait_cyc(4);
    endtask
endmodule // swbc_host_model

//--- tb/testbench.sv
// self-checking bench for the single-wire byte commands
`timescale 1ns/1ps
module testbench;
    import swbc_pkg::*;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sclIn, sdaIn, sdaOut, sdaOe, owOut, owOe, err, ackC, ackD;
    logic activePullupOut, strongPullupOut, weakPullupSelOut, busBusyFlag;
    logic owIn = 1'b1;
    logic owOePrev = 1'b1;
    logic apuSeen = 1'b0;
    logic [7:0] capByte = 8'h00;
    logic [7:0] slavePat = 8'hFF;
    logic [7:0] wdat [2] = '{8'hB2, 8'h4D};
    int lowCnt = 0, slotCnt = 0, busyCnt = 0, holdCnt = 0, slaveIdx = 0, slot;
    int fail_count = 0;
    int total_checks = 0;

    swbc_top i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .owIn(owIn), .owOut(owOut), .owOe(owOe),
        .activePullupOut(activePullupOut), .strongPullupOut(strongPullupOut),
        .weakPullupSelOut(weakPullupSelOut), .busBusyFlag(busBusyFlag));
    swbc_host_model i_host (.ref_clk(ref_clk), .sdaOe(sdaOe), .sdaOut(sdaOut),
        .sclIn(sclIn), .sdaLine(sdaIn));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // slot monitor: short low phase reads as a one; slave holds the line low for zero bits
    // runs on the falling edge so it never races the registered line outputs
    always @(negedge ref_clk) begin
        owOePrev <= owOe;
        busyCnt <= busyCnt + int'(busBusyFlag === 1'b1);
        if (activePullupOut === 1'b1) apuSeen <= 1'b1;
        if (owOe === 1'b0) lowCnt <= lowCnt + 1;
        if (owOePrev === 1'b0 && owOe === 1'b1) begin
            capByte <= {(lowCnt < 4), capByte[7:1]};
            slotCnt <= slotCnt + 1;
            lowCnt <= 0;
        end
        if (owOePrev === 1'b1 && owOe === 1'b0) begin
            holdCnt <= slavePat[slaveIdx[2:0]] ? 0 : 14;
            slaveIdx <= slaveIdx + 1;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
        owIn <= !(owOe === 1'b0 || holdCnt > 0);
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // pready is looked at mid-cycle, so the edge that samples it high is the next rising one
        @(negedge ref_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask

    task automatic clr_mon();
        slotCnt = 0;
        busyCnt = 0;
        slaveIdx = 0;
        apuSeen = 1'b0;
    endtask

    task automatic wait_idle(input int limit);
        int n;
        n = 0;
        while (busBusyFlag !== 1'b0 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        chk("busy end", 32'(n <= limit), 32'h1);
        repeat (3) @(posedge ref_clk);
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd_chk(ADDR_CFG, 32'h0000_0000, "cfg reset");
        rd_chk(ADDR_TSTD, TSTD_RST, "tstd reset");
        rd_chk(ADDR_TOVD, TOVD_RST, "tovd reset");
        rd_chk(ADDR_TSAMP, TSAMP_RST, "tsamp reset");
        rd_chk(ADDR_STATUS, 32'h0000_0000, "status reset");
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped error", 32'(err), 32'h1);
        // short slots: std 6 low + 14 recovery, ovd 4 + 8; sample late enough for the synchroniser
        apb(1'b1, ADDR_TSTD, 32'h000E_0006);
        apb(1'b1, ADDR_TOVD, 32'h0008_0004);
        apb(1'b1, ADDR_TSAMP, 32'h0602_0A02);
        for (int k = 0; k < 2; k++) begin
            slot = (k == 0) ? 20 : 12;
            apb(1'b1, ADDR_CFG, (k == 0) ? 32'h0000_0006 : 32'h0000_0007);
            apb(1'b1, ADDR_PTR, 32'h0000_0001);
            clr_mon();
            i_host.send_cmd(CMD_WRITE_BYTE, 1'b1, wdat[k], ackC, ackD);
            chk("write acks", 32'({ackC, ackD}), 32'h3);
            chk("busy by data ack", 32'(busBusyFlag), 32'h1);
            if (k == 0) begin
                // polled while the first write still runs; the refused command outlasts it
                rd_chk(ADDR_STATUS, 32'h0000_0001, "status in write");
                i_host.send_cmd(CMD_WRITE_BYTE, 1'b1, 8'hFF, ackC, ackD);
                chk("refused write acks", 32'({ackC, ackD}), 32'h0);
            end
            wait_idle(8 * slot + ACT_MAX_CYC);
            chk("write slots", 32'(slotCnt), 32'h8);
            chk("write byte", 32'(capByte), 32'(wdat[k]));
            chk("write busy span", 32'(busyCnt >= 8 * slot && busyCnt <= 8 * slot + 2),
                32'h1);
            chk("strong pullup", 32'(strongPullupOut), 32'h1);
            chk("active pullup", 32'(apuSeen), 32'h1);
        end
        // strong pullup left enabled: the read command must not use it
        apb(1'b1, ADDR_CFG, 32'h0000_000E);
        chk("weak pullup select", 32'(weakPullupSelOut), 32'h1);
        chk("open drain values", 32'({sdaOut, owOut}), 32'h0);
        apb(1'b1, ADDR_PTR, 32'h0000_0001);
        clr_mon();
        slavePat = 8'h5C;
        i_host.send_cmd(CMD_READ_BYTE, 1'b0, 8'h00, ackC, ackD);
        chk("read ack", 32'(ackC), 32'h1);
        chk("strong pullup off", 32'(strongPullupOut), 32'h0);
        i_host.send_cmd(CMD_READ_BYTE, 1'b0, 8'h00, ackC, ackD);
        chk("refused read ack", 32'(ackC), 32'h0);
        rd_chk(ADDR_STATUS, 32'h0000_0001, "status in read");
        wait_idle(8 * 20 + ACT_MAX_CYC);
        chk("read slots", 32'(slotCnt), 32'h8);
        chk("read slot shape", 32'(capByte), 32'h0000_00FF);
        chk("read busy span", 32'(busyCnt >= 160 && busyCnt <= 162), 32'h1);
        chk("no strong pullup after read", 32'(strongPullupOut), 32'h0);
        chk("read active pullup", 32'(apuSeen), 32'h1);
        apb(1'b1, ADDR_PTR, 32'h0000_0001);
        rd_chk(ADDR_RDATA, 32'h0000_015C, "read byte");
        apb(1'b0, ADDR_RDATA, 32'h0000_0000);
        chk("fifo empty", 32'(rd[8]), 32'h0);
        // fill the buffer until the read command is refused, then drain it
        for (int i = 0; i < 17; i++) begin
            clr_mon();
            slavePat = 8'(i);
            i_host.send_cmd(CMD_READ_BYTE, 1'b0, 8'h00, ackC, ackD);
            chk("fill ack", 32'(ackC), 32'(i < 16));
            wait_idle(8 * 20 + ACT_MAX_CYC);
        end
        rd_chk(ADDR_STATUS, 32'h0000_0018, "status full");
        apb(1'b1, ADDR_PTR, 32'h0000_0001);
        for (int i = 0; i < 16; i++) begin
            rd_chk(ADDR_RDATA, 32'h0000_0100 | 32'(i), "drain byte");
        end
        apb(1'b0, ADDR_RDATA, 32'h0000_0000);
        chk("drained", 32'(rd[8]), 32'h0);
        close_out();
    end
endmodule // testbench
